// ===== logic/pic_pkg.sv
// package: constants and carriers for the priority interrupt controller
package pic_pkg;
  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned MASK_W  = 4;
  localparam int unsigned ADDR_W  = 12;
  // latch index: 4 high pin, 3 timer one, 2 timer two, 1 tick, 0 low pin
  localparam int unsigned SRC_HIGH = 4;
  localparam int unsigned SRC_T1   = 3;
  localparam int unsigned SRC_T2   = 2;
  localparam int unsigned SRC_TICK = 1;
  localparam int unsigned SRC_LOW  = 0;
  // mask bit positions
  localparam int unsigned MASK_BIT_T1   = 2;
  localparam int unsigned MASK_BIT_T2TK = 1;
  localparam int unsigned MASK_BIT_LOW  = 0;
  // reset values
  localparam logic [MASK_W-1:0]   MASK_RESET  = 4'h0;
  localparam logic [NUM_SRC-1:0]  LATCH_RESET = 5'h00;
  localparam logic                ENABLE_RESET = 1'b0;
  // entry addresses
  localparam logic [ADDR_W-1:0] ENTRY_HIGH = 12'h002;
  localparam logic [ADDR_W-1:0] ENTRY_T1   = 12'h006;
  localparam logic [ADDR_W-1:0] ENTRY_T2   = 12'h008;
  localparam logic [ADDR_W-1:0] ENTRY_TICK = 12'h00a;
  localparam logic [ADDR_W-1:0] ENTRY_LOW  = 12'h00c;
  // acknowledge length in instruction cycles
  localparam int unsigned ACK_CYCLES = 2;

  // cpu-side instruction strobes, one-cycle pulses
  typedef struct packed {
    logic                enable_and_clear;
    logic                disable_and_clear;
    logic                clear_latches;
    logic [NUM_SRC-1:0]  latch_field;
    logic                return_from_irq;
    logic                exchange_op;
    logic [MASK_W-1:0]   exchange_data;
  } pic_cmd_t;

  // vector handed to the cpu at acknowledge
  typedef struct packed {
    logic                valid;
    logic [ADDR_W-1:0]   entry;
    logic [NUM_SRC-1:0]  source;
  } pic_vec_t;
endpackage

// ===== logic/pic_edge_sync.sv
// two-flop synchroniser with falling-edge pulse
`timescale 1ns/10ps
module pic_edge_sync (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // pin
  input  wire logic pin_in,
  // event
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // idle-high reset so an idle pin gives no false edge at release
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign fall_out = prev_q & ~sync_q;
endmodule

// ===== logic/pic_ctrl.sv
// prioritised interrupt controller core
`timescale 1ns/10ps
module pic_ctrl #(
  parameter int unsigned ACK_LEN = pic_pkg::ACK_CYCLES
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  // pins
  input  wire logic              ext_pin_irq_high_in,
  input  wire logic              ext_pin_irq_low_in,
  // internal requests, one-cycle pulses
  input  wire logic              timer_one_overflow_irq_in,
  input  wire logic              timer_two_overflow_irq_in,
  input  wire logic              interval_tick_irq_in,
  // cpu timing
  input  wire logic              instr_cycle_in,
  input  wire logic              instr_boundary_in,
  input  wire logic              timer_busy_in,
  // cpu commands
  input  wire pic_pkg::pic_cmd_t cmd_in,
  // answers to cpu
  output pic_pkg::pic_vec_t      vec_out,
  output logic                   ack_busy_out,
  output logic                   push_ctx_out,
  output logic                   restore_ctx_out,
  output logic                   set_branch_flag_out,
  output logic [pic_pkg::MASK_W-1:0]  exchange_old_out,
  // status
  output logic                   master_irq_enable_out,
  output logic [pic_pkg::MASK_W-1:0]  irq_mask_register_out,
  output logic [pic_pkg::NUM_SRC-1:0] pending_latch_out
);
  import pic_pkg::*;

  typedef enum logic [1:0] {PIC_IDLE, PIC_ACK, PIC_DONE} pic_state_t;

  logic [NUM_SRC-1:0] pending_latch_q;
  logic [NUM_SRC-1:0] pending_latch_d;
  logic [MASK_W-1:0]  irq_mask_register_q;
  logic               master_irq_enable_q;
  logic               master_irq_enable_d;
  pic_state_t         state_q;
  pic_state_t         state_d;
  logic [1:0]         cyc_q;
  pic_vec_t           vec_q;
  logic [MASK_W-1:0]  old_q;
  logic               restore_q;
  logic               high_fall;
  logic               low_fall;
  logic [NUM_SRC-1:0] req_set;
  logic [NUM_SRC-1:0] enabled;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] winner;
  logic [ADDR_W-1:0]  winner_entry;
  logic [NUM_SRC-1:0] field_clear;
  logic [NUM_SRC-1:0] ack_clear;
  logic               accept;
  logic               ack_end;

  // one-hot pick, highest index wins
  function automatic logic [NUM_SRC-1:0] pick_top(
    input logic [NUM_SRC-1:0] req
  );
    logic [NUM_SRC-1:0] r;
    logic               found;
    r     = '0;
    found = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && !found) begin
        r[i]  = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // pin edges
  pic_edge_sync u_high_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .pin_in   (ext_pin_irq_high_in),
    .fall_out (high_fall)
  );

  pic_edge_sync u_low_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .pin_in   (ext_pin_irq_low_in),
    .fall_out (low_fall)
  );

  // request vector, pins by falling edge
  assign req_set = {high_fall,
                    timer_one_overflow_irq_in,
                    timer_two_overflow_irq_in,
                    interval_tick_irq_in,
                    low_fall};

  // enable per source
  assign enabled[SRC_HIGH] = 1'b1;
  assign enabled[SRC_T1]   = irq_mask_register_q[MASK_BIT_T1];
  assign enabled[SRC_T2]   = irq_mask_register_q[MASK_BIT_T2TK];
  assign enabled[SRC_TICK] = irq_mask_register_q[MASK_BIT_T2TK];
  assign enabled[SRC_LOW]  = irq_mask_register_q[MASK_BIT_LOW];

  assign eligible = pending_latch_q & enabled
                    & {NUM_SRC{master_irq_enable_q}};
  assign winner   = pick_top(eligible);

  // entry address of the winner
  assign winner_entry = winner[SRC_HIGH] ? ENTRY_HIGH :
                        winner[SRC_T1]   ? ENTRY_T1   :
                        winner[SRC_T2]   ? ENTRY_T2   :
                        winner[SRC_TICK] ? ENTRY_TICK :
                        ENTRY_LOW;

  // accept only at a boundary with no timer work outstanding
  assign accept = (state_q == PIC_IDLE) && instr_boundary_in
                  && !timer_busy_in && (|eligible);

  assign ack_end = (state_q == PIC_ACK) && instr_cycle_in
                   && (cyc_q == 2'(ACK_LEN - 1));

  // latch updates; new request wins over any clear
  assign field_clear = (cmd_in.enable_and_clear || cmd_in.disable_and_clear
                        || cmd_in.clear_latches)
                       ? ~cmd_in.latch_field : '0;
  assign ack_clear   = accept ? winner : '0;
  assign pending_latch_d = (pending_latch_q & ~field_clear & ~ack_clear)
                           | req_set;

  // master enable: accept beats software set and return
  always_comb begin
    master_irq_enable_d = master_irq_enable_q;
    if (cmd_in.return_from_irq || cmd_in.enable_and_clear) begin
      master_irq_enable_d = 1'b1;
    end
    if (cmd_in.disable_and_clear) begin
      master_irq_enable_d = 1'b0;
    end
    if (accept) begin
      master_irq_enable_d = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PIC_IDLE: begin
        if (accept) begin
          state_d = PIC_ACK;
        end
      end
      PIC_ACK: begin
        if (ack_end) begin
          state_d = PIC_DONE;
        end
      end
      PIC_DONE: begin
        state_d = PIC_IDLE;
      end
      default: begin
        state_d = PIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pending_latch_q     <= LATCH_RESET;
      master_irq_enable_q <= ENABLE_RESET;
      irq_mask_register_q <= MASK_RESET;
      state_q             <= PIC_IDLE;
      cyc_q               <= 2'h0;
      vec_q               <= '0;
      old_q               <= MASK_RESET;
      restore_q           <= 1'b0;
    end else begin
      pending_latch_q     <= pending_latch_d;
      master_irq_enable_q <= master_irq_enable_d;
      state_q             <= state_d;
      restore_q           <= cmd_in.return_from_irq;
      if (cmd_in.exchange_op) begin
        irq_mask_register_q <= cmd_in.exchange_data;
        old_q               <= irq_mask_register_q;
      end
      if (accept) begin
        cyc_q       <= 2'h0;
        vec_q.valid <= 1'b1;
        vec_q.entry <= winner_entry;
        vec_q.source <= winner;
      end else if (state_q == PIC_ACK && instr_cycle_in) begin
        cyc_q <= cyc_q + 2'h1;
      end
      if (state_q == PIC_DONE) begin
        vec_q.valid <= 1'b0;
      end
    end
  end

  // context save and entry load belong to the cpu; we only strobe them
  assign vec_out               = vec_q;
  assign ack_busy_out          = (state_q != PIC_IDLE);
  assign push_ctx_out          = (state_q == PIC_DONE);
  assign set_branch_flag_out   = (state_q == PIC_DONE);
  assign restore_ctx_out       = restore_q;
  assign exchange_old_out      = old_q;
  assign master_irq_enable_out = master_irq_enable_q;
  assign irq_mask_register_out = irq_mask_register_q;
  assign pending_latch_out     = pending_latch_q;
endmodule

// ===== verification/pic_cpu_model.sv
// cpu timing model: instruction cycle and boundary strobes
`timescale 1ns/10ps
module pic_cpu_model (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic reset_in,
  // long instructions when high
  input  wire logic slow_in,
  // strobes to the controller
  output logic      instr_cycle_out,
  output logic      instr_boundary_out
);
  logic [2:0] phase_q;
  // boundary trails the cycle strobe so an accept never shares its edge
  assign instr_cycle_out    = (phase_q == 3'h0);
  assign instr_boundary_out = (phase_q == 3'h1);
  always_ff @(posedge clk_in) begin
    if (reset_in || phase_q == {slow_in, 2'h3}) phase_q <= 3'h0;
    else phase_q <= phase_q + 3'h1;
  end
endmodule

// ===== verification/pic_ctrl_props.sv
// concurrent checks on the interrupt controller ports
`timescale 1ns/10ps
module pic_ctrl_props #(
  parameter int unsigned ACK_LEN = pic_pkg::ACK_CYCLES
) (
  // clock and reset
  input wire logic                        clk_in,
  input wire logic                        reset_in,
  // requests, timing and commands
  input wire logic                        timer_one_overflow_irq_in,
  input wire logic                        instr_cycle_in,
  input wire logic                        instr_boundary_in,
  input wire logic                        timer_busy_in,
  input wire pic_pkg::pic_cmd_t           cmd_in,
  // controller outputs
  input wire pic_pkg::pic_vec_t           vec_out,
  input wire logic                        push_ctx_out,
  input wire logic                        set_branch_flag_out,
  input wire logic                        master_irq_enable_out,
  input wire logic [pic_pkg::MASK_W-1:0]  irq_mask_register_out,
  input wire logic [pic_pkg::NUM_SRC-1:0] pending_latch_out
);
  import pic_pkg::*;
  logic [3:0]        cyc_q;
  logic [ADDR_W-1:0] entry_exp;
  assign entry_exp = vec_out.source[SRC_HIGH] ? ENTRY_HIGH :
                     vec_out.source[SRC_T1]   ? ENTRY_T1 :
                     vec_out.source[SRC_T2]   ? ENTRY_T2 :
                     vec_out.source[SRC_TICK] ? ENTRY_TICK : ENTRY_LOW;
  // cycles seen inside one acknowledge
  always_ff @(posedge clk_in) begin
    if (reset_in || !vec_out.valid) cyc_q <= 4'h0;
    else if (instr_cycle_in && !push_ctx_out) cyc_q <= cyc_q + 4'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_taken;
    $rose(vec_out.valid) && !master_irq_enable_out;
  endsequence
  sequence s_done;
    push_ctx_out && set_branch_flag_out ##1 !push_ctx_out && !vec_out.valid;
  endsequence
  AST_ACK_GATE: assert property ($rose(vec_out.valid) |->
    $past(instr_boundary_in) && $past(master_irq_enable_out)
    && !$past(timer_busy_in)) else $error("accept without permission");
  AST_ACK_CLEARS_EN: assert property ($rose(vec_out.valid) |-> s_taken)
    else $error("enable left set on accept");
  AST_ENTRY: assert property (vec_out.valid |->
    $onehot(vec_out.source) && vec_out.entry == entry_exp)
    else $error("wrong entry address");
  AST_ACK_LEN: assert property (push_ctx_out |-> cyc_q == ACK_LEN)
    else $error("acknowledge length wrong");
  AST_DONE: assert property ($rose(push_ctx_out) |-> s_done)
    else $error("push or branch pulse wrong");
  AST_SET_EN: assert property ((cmd_in.return_from_irq
    || cmd_in.enable_and_clear) && !cmd_in.disable_and_clear
    && !master_irq_enable_out |=> master_irq_enable_out)
    else $error("enable not set");
  AST_CLR_EN: assert property (cmd_in.disable_and_clear |=>
    !master_irq_enable_out) else $error("enable not cleared");
  AST_EXCHANGE: assert property (cmd_in.exchange_op |=>
    irq_mask_register_out == $past(cmd_in.exchange_data))
    else $error("mask not loaded");
  AST_NO_SET: assert property ($rose(pending_latch_out[SRC_T1]) |->
    $past(timer_one_overflow_irq_in)) else $error("latch set by itself");
endmodule

// ===== verification/tb_top.sv
// self-checking testbench for the priority interrupt controller
`timescale 1ns/10ps
module tb_top;
  import pic_pkg::*;
  typedef struct packed {
    logic [4:0]  req;
    logic [3:0]  mask;
    logic [4:0]  win;
    logic [11:0] entry;
  } pic_row_t;
  logic       clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       p_hi = 1'b1, p_lo = 1'b1, t1 = 1'b0, t2 = 1'b0, tk = 1'b0;
  logic       tbusy = 1'b0, slow = 1'b0, icyc, ibnd, abusy, push, rctx, brf, en;
  pic_cmd_t   cmd = '0;
  pic_vec_t   vec;
  logic [3:0] old, mask, prev = 4'h0;
  logic [4:0] pend;
  int         failures = 0, n_tests = 0;
  pic_row_t   rows[10] = '{'{5'h10, 4'h0, 5'h10, 12'h002},
    '{5'h08, 4'h4, 5'h08, 12'h006}, '{5'h04, 4'h2, 5'h04, 12'h008},
    '{5'h02, 4'h2, 5'h02, 12'h00a}, '{5'h01, 4'h1, 5'h01, 12'h00c},
    '{5'h1f, 4'hf, 5'h10, 12'h002}, '{5'h0f, 4'hf, 5'h08, 12'h006},
    '{5'h07, 4'h3, 5'h04, 12'h008}, '{5'h03, 4'h3, 5'h02, 12'h00a},
    '{5'h0f, 4'h3, 5'h04, 12'h008}};
  always #10 clk_in = ~clk_in;
  pic_cpu_model cpu (.clk_in(clk_in), .reset_in(reset_in), .slow_in(slow),
    .instr_cycle_out(icyc), .instr_boundary_out(ibnd));
  pic_ctrl dut (.clk_in(clk_in), .reset_in(reset_in),
    .ext_pin_irq_high_in(p_hi), .ext_pin_irq_low_in(p_lo),
    .timer_one_overflow_irq_in(t1), .timer_two_overflow_irq_in(t2),
    .interval_tick_irq_in(tk), .instr_cycle_in(icyc),
    .instr_boundary_in(ibnd), .timer_busy_in(tbusy), .cmd_in(cmd),
    .vec_out(vec), .ack_busy_out(abusy), .push_ctx_out(push),
    .restore_ctx_out(rctx), .set_branch_flag_out(brf),
    .exchange_old_out(old), .master_irq_enable_out(en),
    .irq_mask_register_out(mask), .pending_latch_out(pend));
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input pic_cmd_t c);
    @(posedge clk_in) cmd <= c;
    @(posedge clk_in) cmd <= '0;
    @(negedge clk_in);
  endtask
  task automatic raise(input logic [4:0] r);
    @(posedge clk_in) {p_hi, t1, t2, tk, p_lo} <= r ^ 5'h11;
    @(posedge clk_in) {t1, t2, tk} <= 3'h0;
    repeat (4) @(posedge clk_in);
    {p_hi, p_lo} <= 2'h3;
    @(negedge clk_in);
  endtask
  task automatic wait_ack();
    for (int i = 0; i < 80 && !vec.valid; i++) @(negedge clk_in);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    results();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      slow <= i[0];
      send('{disable_and_clear: 1'b1, default: '0});
      send('{exchange_op: 1'b1, exchange_data: rows[i].mask, default: '0});
      @(negedge clk_in);
      check("mask", mask, rows[i].mask);
      check("old mask", old, prev);
      raise(rows[i].req);
      check("latches", pend, rows[i].req);
      send('{enable_and_clear: 1'b1, latch_field: 5'h1f, default: '0});
      wait_ack();
      check("entry", vec.entry, rows[i].entry);
      check("source", vec.source, rows[i].win);
      check("busy", abusy, 1'b1);
      check("enable", en, 1'b0);
      check("left", pend, rows[i].req & ~rows[i].win);
      for (int k = 0; k < 80 && !push; k++) @(negedge clk_in);
      check("branch", brf, 1'b1);
      check("push", push, 1'b1);
      prev = rows[i].mask;
    end
    // disabled: request waits
    // drop latches the last row left behind
    send('{disable_and_clear: 1'b1, default: '0});
    send('{exchange_op: 1'b1, exchange_data: 4'h4, default: '0});
    raise(5'h08);
    repeat (20) @(negedge clk_in);
    check("gated", vec.valid, 1'b0);
    check("held", pend, 5'h08);
    @(posedge clk_in) tbusy <= 1'b1;
    send('{return_from_irq: 1'b1, default: '0});
    check("restore", rctx, 1'b1);
    repeat (20) @(negedge clk_in);
    check("return", en, 1'b1);
    check("timer busy", vec.valid, 1'b0);
    @(posedge clk_in) tbusy <= 1'b0;
    wait_ack();
    check("late entry", vec.entry, ENTRY_T1);
    raise(5'h06);
    send('{clear_latches: 1'b1, latch_field: 5'h1b, default: '0});
    check("field", pend, 5'h02);
    send('{enable_and_clear: 1'b1, latch_field: 5'h1f, default: '0});
    repeat (30) @(negedge clk_in);
    check("masked", vec.valid, 1'b0);
    @(posedge clk_in) reset_in <= 1'b1;
    @(posedge clk_in) reset_in <= 1'b0;
    @(negedge clk_in);
    check("reset", {en, mask, pend}, 10'h0);
    check("reset ack", {abusy, vec.valid, rctx}, 3'h0);
    results();
  end
endmodule
bind pic_ctrl pic_ctrl_props #(.ACK_LEN(ACK_LEN)) u_props (.clk_in(clk_in),
  .reset_in(reset_in), .timer_one_overflow_irq_in(timer_one_overflow_irq_in),
  .instr_cycle_in(instr_cycle_in), .instr_boundary_in(instr_boundary_in),
  .timer_busy_in(timer_busy_in), .cmd_in(cmd_in), .vec_out(vec_out),
  .push_ctx_out(push_ctx_out), .set_branch_flag_out(set_branch_flag_out),
  .master_irq_enable_out(master_irq_enable_out),
  .irq_mask_register_out(irq_mask_register_out),
  .pending_latch_out(pending_latch_out));
